// *** common/sdpc_consts.svh ***
`ifndef SDPC_CONSTS_SVH
`define SDPC_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SDPC_CLK_HZ     100000000
`define SDPC_CLK_NS     10
`define SDPC_BAUD       38400
`define SDPC_TICK_NS    1000000

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SDPC_A_CTRL     8'h00
`define SDPC_A_GEAR     8'h04
`define SDPC_A_LIMIT    8'h08
`define SDPC_A_BAUD     8'h0c
`define SDPC_A_SPEED    8'h10
`define SDPC_A_ACCEL    8'h14
`define SDPC_A_DIST     8'h18
`define SDPC_A_LINES    8'h1c
`define SDPC_A_STAT     8'h20
`define SDPC_A_HIST     8'h24
`define SDPC_A_MASK     8'h28
`define SDPC_A_CMD      8'h2c
`define SDPC_A_MEAS     8'h30
`define SDPC_A_ERR      8'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SDPC_C_EDGE     0
`define SDPC_C_REV      1
`define SDPC_C_CCW      2
`define SDPC_C_START    3
`define SDPC_C_STOP     4
`define SDPC_C_LOAD     5
`define SDPC_C_CLRNOW   6
`define SDPC_C_CLRALL   7
`define SDPC_C_RUN      8
`define SDPC_S_TRACK    0
`define SDPC_S_PHASE    1
`define SDPC_S_SENSOR   2
`define SDPC_G_BOT      8

// ----------------------------------------
// Reset values and answers
// ----------------------------------------
`define SDPC_R_GEAR     8'h01
`define SDPC_R_LIMIT    32'h0000_0fa0
`define SDPC_R_LINES    16'h0fa0
`define SDPC_R_SPEED    16'h0010
`define SDPC_R_ACCEL    16'h0001
`define SDPC_R_DIST     32'h0000_4000
`define SDPC_RESP_OK    2'h0
`define SDPC_RESP_ERR   2'h2

`endif

// *** common/sdpc_pkg.sv ***
`default_nettype none
package sdpc_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCEL  = 2'b01,
		ST_CRUISE = 2'b10,
		ST_DECEL  = 2'b11
	} sdpc_st_type;

	typedef struct packed {
		logic a;
		logic b;
	} sdpc_enc_type;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} sdpc_axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sdpc_axi_rsp_type;

	typedef struct packed {
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        edge_down;
		logic        reverse;
		logic        ccw_mode;
		logic [7:0]  stage_top;
		logic [7:0]  stage_bot;
		logic [31:0] stage_limit;
		logic [7:0]  top;
		logic [7:0]  bot;
		logic [31:0] limit;
		logic [15:0] baud_div;
		logic [15:0] baud_cnt;
		logic        baud_tick;
		logic [15:0] st_speed;
		logic [15:0] st_accel;
		logic [31:0] st_dist;
		logic [15:0] enc_lines;
		logic [2:0]  status;
		logic [2:0]  history;
		logic [2:0]  mask;
		logic [31:0] cmd_pos;
		logic [7:0]  rem;
		logic [31:0] meas_pos;
		logic [31:0] tick_cnt;
		sdpc_st_type st;
		logic [15:0] st_vel;
		logic [16:0] st_phase;
		logic [31:0] st_done;
		logic [31:0] st_ramp;
	} sdpc_state_type;

endpackage : sdpc_pkg
`default_nettype wire

// *** rtl/sdpc_edges.sv ***
`timescale 1ns/10ps
`default_nettype none
module sdpc_edges #(
	parameter int unsigned W = 2
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] level,
	output var  logic [W-1:0] rise,
	output var  logic [W-1:0] fall
);
	import sdpc_pkg::*;

	typedef struct packed {
		logic [W-1:0] prev;
	} sdpc_edge_state_type;

	sdpc_edge_state_type q;
	sdpc_edge_state_type d;

	always_comb begin
		d      = q;
		d.prev = din;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Follows the pin in reset, so a level held through it is no edge
			q.prev <= din;
		end else begin
			q <= d;
		end
	end

	// Previous level
	assign level = q.prev;
	assign rise  = din & ~q.prev;
	assign fall  = ~din & q.prev;

	edge_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rise[0] |=> level[0]) else $error("edge tracker lost a rising level");

endmodule : sdpc_edges
`default_nettype wire

// *** rtl/sdpc_top.sv ***
// Operation
// - Gear numerator is 1..255 and multiplies incoming step counts.
// - Gear denominator is 1..255 and divides the scaled step count.
// - Command minus measured position is checked every cycle; reaching the limit faults.
// - Encoder counts every edge of both channels, four counts per line.
// - Line count feeds only the self-test generator, never feedback decoding.
// - Step is taken on the rising or the falling edge, as the edge bit selects, the same edge for both directions.
// - In CW/CCW mode a static level on either input causes no motion.
// - Reverse swaps the rotation sense for a given direction level.
// - A wiring or sensor fault lights the fault indicator on the next clock and is recorded.
// - A download replaces the active parameter set with the staged one.
// - Self-test makes a trapezoid from speed, acceleration and distance on command.
// - Serial link rate defaults to 38400 baud and software may change it.
// - Present errors and history are kept and cleared by separate commands.
`timescale 1ns/10ps
`default_nettype none
`include "sdpc_consts.svh"
module sdpc_top #(
	parameter int unsigned TICK_CYC = `SDPC_TICK_NS / `SDPC_CLK_NS
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire sdpc_pkg::sdpc_axi_req_type axi_req,
	output var  sdpc_pkg::sdpc_axi_rsp_type axi_rsp,
	input  wire logic                      step_pulse_input,
	input  wire logic                      dir_input,
	input  wire sdpc_pkg::sdpc_enc_type     enc,
	input  wire logic                      wiring_phase_fault,
	input  wire logic                      feedback_sensor_fault,
	output var  logic                      fault_led,
	output var  logic                      irq,
	output var  logic                      baud_tick,
	output var  logic                      st_running
);
	import sdpc_pkg::*;

	sdpc_state_type q;
	sdpc_state_type d;
	logic [1:0]     pin_rise;
	logic [1:0]     pin_fall;
	logic [1:0]     enc_lvl;
	logic [1:0]     act_edge;
	logic           raw_up;
	logic           raw_dn;
	logic           pin_up;
	logic           pin_dn;
	logic           st_run;
	logic           st_tick;
	logic           st_step;
	logic [31:0]    remaining;
	logic           ch_a;
	logic           ch_b;
	logic           enc_bad;
	logic           enc_move;
	logic           enc_up;
	logic [31:0]    err;
	logic [31:0]    abs_err;
	logic           track_ev;
	logic [2:0]     events;
	logic           awready;
	logic           wready;
	logic           arready;
	logic           wr_fire;
	logic [32:0]    rd_word;
	logic [32:0]    wr_word;
	logic [31:0]    mw;
	logic [2:0]     w1c;
	logic           go_start;
	logic           go_stop;
	logic           go_load;
	logic           clr_now;
	logic           clr_all;
	logic [8:0]     g_num;
	logic [8:0]     g_q;
	logic [7:0]     g_r;

	// ----------------------------------------
	// Input edge trackers
	// ----------------------------------------
	sdpc_edges #(.W(2)) u_pin_edges (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     ({dir_input, step_pulse_input}),
		.level   (),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	sdpc_edges #(.W(2)) u_enc_edges (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     ({enc.b, enc.a}),
		.level   (enc_lvl),
		.rise    (),
		.fall    ()
	);

	// ----------------------------------------
	// Step decode
	// ----------------------------------------
	assign act_edge = q.edge_down ? pin_fall : pin_rise;
	// CW/CCW mode reacts to edges only, so a held level is harmless
	assign raw_up = q.ccw_mode ? (act_edge[0] & ~act_edge[1])
		: (act_edge[0] & ~dir_input);
	assign raw_dn = q.ccw_mode ? (act_edge[1] & ~act_edge[0])
		: (act_edge[0] & dir_input);
	assign st_run = (q.st != ST_IDLE);
	// Pins are ignored while self-test owns the command
	assign pin_up = ~st_run & (q.reverse ? raw_dn : raw_up);
	assign pin_dn = ~st_run & (q.reverse ? raw_up : raw_dn);

	// ----------------------------------------
	// Quadrature decode
	// ----------------------------------------
	assign ch_a     = enc.a ^ enc_lvl[0];
	assign ch_b     = enc.b ^ enc_lvl[1];
	assign enc_bad  = ch_a & ch_b;
	assign enc_move = ch_a ^ ch_b;
	assign enc_up   = enc.a ^ enc_lvl[1];

	// ----------------------------------------
	// Tracking supervision
	// ----------------------------------------
	assign err      = q.cmd_pos - q.meas_pos;
	assign abs_err  = err[31] ? (32'h0 - err) : err;
	assign track_ev = (abs_err >= q.limit);

	assign events[`SDPC_S_TRACK]  = track_ev;
	assign events[`SDPC_S_PHASE]  = wiring_phase_fault;
	assign events[`SDPC_S_SENSOR] = feedback_sensor_fault | enc_bad;

	// ----------------------------------------
	// Self-test timing
	// ----------------------------------------
	assign st_tick   = (q.tick_cnt >= 32'(TICK_CYC - 1));
	assign remaining = q.st_dist - q.st_done;
	assign st_step   = st_run && (q.st_phase >= 17'(q.enc_lines))
		&& (q.st_done < q.st_dist);

	// ----------------------------------------
	// Bus handshakes and outputs
	// ----------------------------------------
	assign awready = ~q.aw_got & ~q.bvalid;
	assign wready  = ~q.w_got & ~q.bvalid;
	assign arready = ~q.rvalid;
	assign wr_fire = q.aw_got & q.w_got & ~q.bvalid;

	assign axi_rsp.awready = awready;
	assign axi_rsp.wready  = wready;
	assign axi_rsp.bvalid  = q.bvalid;
	assign axi_rsp.bresp   = q.bresp;
	assign axi_rsp.arready = arready;
	assign axi_rsp.rvalid  = q.rvalid;
	assign axi_rsp.rdata   = q.rdata;
	assign axi_rsp.rresp   = q.rresp;

	assign fault_led  = |q.status;
	assign irq        = |(q.status & q.mask);
	assign baud_tick  = q.baud_tick;
	assign st_running = st_run;

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Top bit flags a mapped address
	function automatic logic [32:0] reg_word(input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0};
		case (a)
			`SDPC_A_CTRL: begin
				r[`SDPC_C_EDGE] = q.edge_down;
				r[`SDPC_C_REV]  = q.reverse;
				r[`SDPC_C_CCW]  = q.ccw_mode;
				r[`SDPC_C_RUN]  = st_run;
			end
			`SDPC_A_GEAR:  r[15:0] = {q.stage_bot, q.stage_top};
			`SDPC_A_LIMIT: r[31:0] = q.stage_limit;
			`SDPC_A_BAUD:  r[15:0] = q.baud_div;
			`SDPC_A_SPEED: r[15:0] = q.st_speed;
			`SDPC_A_ACCEL: r[15:0] = q.st_accel;
			`SDPC_A_DIST:  r[31:0] = q.st_dist;
			`SDPC_A_LINES: r[15:0] = q.enc_lines;
			`SDPC_A_STAT:  r[2:0]  = q.status;
			`SDPC_A_HIST:  r[2:0]  = q.history;
			`SDPC_A_MASK:  r[2:0]  = q.mask;
			`SDPC_A_CMD:   r[31:0] = q.cmd_pos;
			`SDPC_A_MEAS:  r[31:0] = q.meas_pos;
			`SDPC_A_ERR:   r[31:0] = err;
			default:       r       = '0;
		endcase
		return r;
	endfunction : reg_word

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d        = q;
		rd_word  = reg_word(axi_req.araddr);
		wr_word  = reg_word(q.awaddr);
		mw       = merge(wr_word[31:0], q.wdata, q.wstrb);
		w1c      = '0;
		go_start = 1'b0;
		go_stop  = 1'b0;
		go_load  = 1'b0;
		clr_now  = 1'b0;
		clr_all  = 1'b0;
		// Gear step with carried remainder
		g_num = pin_up ? (9'(q.rem) + 9'(q.top))
			: (9'(q.bot) - 9'h1 - 9'(q.rem) + 9'(q.top));
		g_q   = g_num / 9'(q.bot);
		g_r   = 8'(g_num % 9'(q.bot));

		if (axi_req.awvalid && awready) begin
			d.aw_got = 1'b1;
			d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && wready) begin
			d.w_got = 1'b1;
			d.wdata = axi_req.wdata;
			d.wstrb = axi_req.wstrb;
		end
		if (q.bvalid && axi_req.bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = wr_word[32] ? `SDPC_RESP_OK : `SDPC_RESP_ERR;
			case (q.awaddr)
				`SDPC_A_CTRL: begin
					if (q.wstrb[0]) begin
						d.edge_down = q.wdata[`SDPC_C_EDGE];
						d.reverse   = q.wdata[`SDPC_C_REV];
						d.ccw_mode  = q.wdata[`SDPC_C_CCW];
						go_start    = q.wdata[`SDPC_C_START];
						go_stop     = q.wdata[`SDPC_C_STOP];
						go_load     = q.wdata[`SDPC_C_LOAD];
						clr_now     = q.wdata[`SDPC_C_CLRNOW];
						clr_all     = q.wdata[`SDPC_C_CLRALL];
					end
				end
				`SDPC_A_GEAR: begin
					d.stage_top = mw[7:0];
					d.stage_bot = mw[`SDPC_G_BOT +: 8];
				end
				`SDPC_A_LIMIT: d.stage_limit = mw;
				`SDPC_A_BAUD:  d.baud_div    = mw[15:0];
				`SDPC_A_SPEED: d.st_speed    = mw[15:0];
				`SDPC_A_ACCEL: d.st_accel    = mw[15:0];
				`SDPC_A_DIST:  d.st_dist     = mw;
				`SDPC_A_LINES: d.enc_lines   = mw[15:0];
				`SDPC_A_STAT: begin
					if (q.wstrb[0]) begin
						w1c = q.wdata[2:0];
					end
				end
				`SDPC_A_MASK:  d.mask = mw[2:0];
				default: begin
				end
			endcase
		end

		if (axi_req.arvalid && arready) begin
			d.rvalid = 1'b1;
			d.rdata  = rd_word[31:0];
			d.rresp  = rd_word[32] ? `SDPC_RESP_OK : `SDPC_RESP_ERR;
		end else if (q.rvalid && axi_req.rready) begin
			d.rvalid = 1'b0;
		end

		// Commanded position
		if (st_step) begin
			d.cmd_pos = q.cmd_pos + 32'h1;
		end else if (pin_up ^ pin_dn) begin
			d.cmd_pos = pin_up ? (q.cmd_pos + 32'(g_q))
				: (q.cmd_pos - 32'(g_q));
			d.rem     = pin_up ? g_r : (q.bot - 8'h1 - g_r);
		end

		// Staged set becomes active; a zero gear term is loaded as one
		if (go_load) begin
			d.top   = (q.stage_top == 8'h0) ? `SDPC_R_GEAR : q.stage_top;
			d.bot   = (q.stage_bot == 8'h0) ? `SDPC_R_GEAR : q.stage_bot;
			d.limit = q.stage_limit;
			d.rem   = 8'h0;
		end

		// Measured position
		if (enc_move) begin
			d.meas_pos = enc_up ? (q.meas_pos + 32'h1) : (q.meas_pos - 32'h1);
		end

		// Present errors and history; a new event beats any clear
		if (clr_now || clr_all) begin
			d.status = events;
		end else begin
			d.status = (q.status & ~w1c) | events;
		end
		d.history = clr_all ? events : (q.history | events);

		// Serial bit-rate enable
		if (q.baud_cnt >= q.baud_div - 16'h1) begin
			d.baud_cnt  = '0;
			d.baud_tick = 1'b1;
		end else begin
			d.baud_cnt  = q.baud_cnt + 16'h1;
			d.baud_tick = 1'b0;
		end

		// Self-test generator
		d.tick_cnt = st_tick ? '0 : (q.tick_cnt + 32'h1);
		if (st_step) begin
			d.st_done  = q.st_done + 32'h1;
			d.st_phase = q.st_phase - 17'(q.enc_lines);
		end else if (st_tick && st_run && (q.st_phase < 17'(q.enc_lines))) begin
			// Adds only below one line so the phase cannot overflow
			d.st_phase = q.st_phase + 17'(q.st_vel);
		end
		case (q.st)
			ST_IDLE: begin
				if (go_start) begin
					d.st       = ST_ACCEL;
					d.st_vel   = '0;
					d.st_phase = '0;
					d.st_done  = '0;
					d.st_ramp  = '0;
				end
			end
			ST_ACCEL: begin
				d.st_ramp = q.st_done;
				if (st_tick) begin
					if (17'(q.st_vel) + 17'(q.st_accel) >= 17'(q.st_speed)) begin
						d.st_vel = q.st_speed;
						d.st     = ST_CRUISE;
					end else begin
						d.st_vel = q.st_vel + q.st_accel;
					end
				end
				// Short moves turn round at the midpoint
				if (remaining <= q.st_done) begin
					d.st = ST_DECEL;
				end
			end
			ST_CRUISE: begin
				if (remaining <= q.st_ramp) begin
					d.st = ST_DECEL;
				end
			end
			ST_DECEL: begin
				// Speed never drops to zero so the move ends
				if (st_tick && (q.st_vel > q.st_accel)) begin
					d.st_vel = q.st_vel - q.st_accel;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		if (st_run && ((remaining == 32'h0) || go_stop)) begin
			d.st = ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q             <= '0;
			q.stage_top   <= `SDPC_R_GEAR;
			q.stage_bot   <= `SDPC_R_GEAR;
			q.top         <= `SDPC_R_GEAR;
			q.bot         <= `SDPC_R_GEAR;
			q.stage_limit <= `SDPC_R_LIMIT;
			q.limit       <= `SDPC_R_LIMIT;
			q.baud_div    <= 16'(`SDPC_CLK_HZ / `SDPC_BAUD);
			q.st_speed    <= `SDPC_R_SPEED;
			q.st_accel    <= `SDPC_R_ACCEL;
			q.st_dist     <= `SDPC_R_DIST;
			q.enc_lines   <= `SDPC_R_LINES;
			q.st          <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	gear_load_a: assert property (go_load |=>
		q.top == (($past(q.stage_top) == 8'h0) ? `SDPC_R_GEAR : $past(q.stage_top)))
		else $error("gear numerator not loaded");
	gear_bot_a: assert property (q.bot != 8'h0)
		else $error("gear denominator zero");
	track_fault_a: assert property (track_ev |=> q.status[`SDPC_S_TRACK])
		else $error("tracking fault not flagged");
	enc_count_a: assert property (enc_move |=>
		(q.meas_pos - $past(q.meas_pos) == 32'h1)
		|| ($past(q.meas_pos) - q.meas_pos == 32'h1))
		else $error("encoder edge not counted once");
	enc_hold_a: assert property (!enc_move |=> $stable(q.meas_pos))
		else $error("feedback moved without an edge");
	step_edge_a: assert property (pin_rise[0] && !q.edge_down && !q.ccw_mode
		&& !st_run && (q.top >= q.bot) |=> $changed(q.cmd_pos))
		else $error("rising step edge ignored");
	ccw_level_a: assert property (q.ccw_mode && (act_edge == 2'h0)
		|-> !(pin_up || pin_dn)) else $error("static level moved the command");
	reverse_a: assert property (!q.ccw_mode && act_edge[0] && !st_run
		&& (dir_input == q.reverse) |-> pin_up) else $error("direction sense wrong");
	fall_mode_a: assert property (q.edge_down && !q.ccw_mode && pin_rise[0]
		|-> !(pin_up || pin_dn)) else $error("step taken on the wrong edge");
	fault_led_a: assert property (wiring_phase_fault |=> fault_led
		&& q.history[`SDPC_S_PHASE]) else $error("wiring fault not shown");
	load_limit_a: assert property (go_load |=> q.limit == $past(q.stage_limit))
		else $error("download did not replace limit");
	self_step_a: assert property (st_step |=>
		q.cmd_pos == $past(q.cmd_pos) + 32'h1) else $error("self-test step not counted");
	baud_gap_a: assert property (q.baud_tick && (q.baud_div > 16'h1)
		|=> !q.baud_tick) else $error("bit-rate enable too dense");
	hist_cover_a: assert property ((q.status & ~q.history) == 3'h0)
		else $error("present error missing from history");
	rem_bound_a: assert property (q.rem < q.bot)
		else $error("gear remainder out of range");

	cover property (track_ev);
	cover property (q.st == ST_DECEL);
	cover property (enc_bad);
	cover property (go_load);

endmodule : sdpc_top
`default_nettype wire

// *** dv/sdpc_motion_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sdpc_motion_model (
	input  wire logic aclk,
	output var  logic step_pulse_input,
	output var  logic dir_input
);
	// ----------------------------------------
	// Controller pins, moved just after an edge
	// ----------------------------------------
	initial begin
		step_pulse_input = 1'b0;
		dir_input        = 1'b0;
	end

	// Each level is held w cycles, so a slow controller is w > 1
	task automatic pulse(input int n, input int w);
		repeat (n) begin
			@(posedge aclk);
			step_pulse_input <= 1'b1;
			repeat (w) @(posedge aclk);
			step_pulse_input <= 1'b0;
			repeat (w - 1) @(posedge aclk);
		end
		repeat (2) @(posedge aclk);
	endtask : pulse

	task automatic set_pin(input logic s, input logic d);
		@(posedge aclk);
		step_pulse_input <= s;
		dir_input        <= d;
		repeat (2) @(posedge aclk);
	endtask : set_pin
endmodule : sdpc_motion_model
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sdpc_consts.svh"
module tb_top;
	import sdpc_pkg::*;
	logic             aclk       = 1'b0;
	logic             aresetn    = 1'b0;
	sdpc_axi_req_type req        = '0;
	sdpc_axi_rsp_type rsp;
	sdpc_enc_type     enc        = '0;
	logic             step;
	logic             dir;
	logic             wpf        = 1'b0;
	logic             fsf        = 1'b0;
	logic             led;
	logic             irq;
	logic             btick;
	logic             run;
	logic [31:0]      rd_v;
	logic [1:0]       rd_r;
	logic [1:0]       wr_b;
	int               fail_count = 0;
	int               num_checks = 0;

	always #5 aclk = ~aclk;

	sdpc_top #(.TICK_CYC(20)) i_sdpc_top (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.step_pulse_input(step), .dir_input(dir), .enc(enc),
		.wiring_phase_fault(wpf), .feedback_sensor_fault(fsf),
		.fault_led(led), .irq(irq), .baud_tick(btick), .st_running(run)
	);
	sdpc_motion_model i_sdpc_motion_model (
		.aclk(aclk), .step_pulse_input(step), .dir_input(dir)
	);

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hf;
		req.bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		wr_b = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rd_v = rsp.rdata;
		rd_r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk(nm, e, rd_v);
	endtask : rchk

	task automatic results();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rchk(`SDPC_A_GEAR, 32'h0000_0101, "gear");
		rchk(`SDPC_A_LIMIT, 32'h0000_0fa0, "limit");
		rchk(`SDPC_A_BAUD, 32'h0000_0a2c, "baud divider");
		rchk(8'h3c, 32'h0, "unmapped read");
		chk("rresp", 32'h2, {30'h0, rd_r});
		wr(8'h3c, 32'h1);
		chk("bresp", 32'h2, {30'h0, wr_b});
	endtask : t_reset

	task automatic t_baud();
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			@(posedge aclk iff btick === 1'b1);
			do begin
				@(posedge aclk);
				n++;
			end while (btick !== 1'b1);
			chk("baud period", (k == 0) ? 32'h0000_0a2c : 32'h10, 32'(n));
			wr(`SDPC_A_BAUD, 32'h10);
		end
	endtask : t_baud

	task automatic t_gear();
		wr(`SDPC_A_GEAR, 32'h0000_0203);
		wr(`SDPC_A_CTRL, 32'h0000_0020);
		i_sdpc_motion_model.pulse(3, 1);
		rchk(`SDPC_A_CMD, 32'h4, "cmd at 3/2");
		wr(`SDPC_A_GEAR, 32'h0000_01ff);
		wr(`SDPC_A_CTRL, 32'h0000_0020);
		i_sdpc_motion_model.pulse(1, 3);
		rchk(`SDPC_A_CMD, 32'h103, "cmd at 255/1");
		wr(`SDPC_A_GEAR, 32'h0000_0101);
		wr(`SDPC_A_CTRL, 32'h0000_0020);
	endtask : t_gear

	task automatic t_edge_dir();
		wr(`SDPC_A_CTRL, 32'h1);
		i_sdpc_motion_model.set_pin(1'b1, 1'b0);
		rchk(`SDPC_A_CMD, 32'h103, "cmd on rise");
		i_sdpc_motion_model.set_pin(1'b0, 1'b0);
		rchk(`SDPC_A_CMD, 32'h104, "cmd on fall");
		wr(`SDPC_A_CTRL, 32'h2);
		i_sdpc_motion_model.pulse(2, 1);
		rchk(`SDPC_A_CMD, 32'h102, "cmd reversed");
		// Direction pin parked high before the mode switch, so no stray edge
		wr(`SDPC_A_CTRL, 32'h0);
		i_sdpc_motion_model.set_pin(1'b0, 1'b1);
		wr(`SDPC_A_CTRL, 32'h4);
		i_sdpc_motion_model.pulse(1, 1);
		rchk(`SDPC_A_CMD, 32'h103, "cw pulse");
		i_sdpc_motion_model.set_pin(1'b0, 1'b0);
		i_sdpc_motion_model.set_pin(1'b0, 1'b1);
		rchk(`SDPC_A_CMD, 32'h102, "ccw pulse");
		i_sdpc_motion_model.set_pin(1'b0, 1'b0);
		wr(`SDPC_A_CTRL, 32'h0);
	endtask : t_edge_dir

	task automatic t_enc();
		logic [1:0] seq [4];
		seq = '{2'b10, 2'b11, 2'b01, 2'b00};
		wr(`SDPC_A_LINES, 32'h1);
		repeat (2) begin
			foreach (seq[i]) begin
				@(posedge aclk);
				enc <= sdpc_enc_type'(seq[i]);
			end
		end
		repeat (2) @(posedge aclk);
		rchk(`SDPC_A_MEAS, 32'h8, "meas");
		rchk(`SDPC_A_ERR, 32'hfa, "track error");
	endtask : t_enc

	task automatic t_track();
		wr(`SDPC_A_MASK, 32'h1);
		wr(`SDPC_A_LIMIT, 32'hfb);
		wr(`SDPC_A_CTRL, 32'h20);
		rchk(`SDPC_A_STAT, 32'h0, "status below limit");
		wr(`SDPC_A_LIMIT, 32'hfa);
		rchk(`SDPC_A_STAT, 32'h0, "status staged limit");
		wr(`SDPC_A_CTRL, 32'h20);
		rchk(`SDPC_A_STAT, 32'h1, "status at limit");
		chk("irq", 32'h1, {31'h0, irq});
		wr(`SDPC_A_MASK, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`SDPC_A_MASK, 32'h1);
		wr(`SDPC_A_LIMIT, 32'h1000);
		wr(`SDPC_A_CTRL, 32'h20);
		wr(`SDPC_A_STAT, 32'h1);
		rchk(`SDPC_A_STAT, 32'h0, "status cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		rchk(`SDPC_A_HIST, 32'h1, "history kept");
		wr(`SDPC_A_CTRL, 32'h80);
		rchk(`SDPC_A_HIST, 32'h0, "history erased");
	endtask : t_track

	task automatic t_fault();
		@(posedge aclk);
		wpf <= 1'b1;
		@(posedge aclk);
		wpf <= 1'b0;
		#1 chk("led phase", 32'h1, {31'h0, led});
		@(posedge aclk);
		fsf <= 1'b1;
		@(posedge aclk);
		fsf <= 1'b0;
		rchk(`SDPC_A_STAT, 32'h6, "status wiring");
		chk("irq unmasked only", 32'h0, {31'h0, irq});
		wr(`SDPC_A_CTRL, 32'h40);
		rchk(`SDPC_A_STAT, 32'h0, "present erased");
		rchk(`SDPC_A_HIST, 32'h6, "history wiring");
		chk("led off", 32'h0, {31'h0, led});
		wr(`SDPC_A_CTRL, 32'h80);
	endtask : t_fault

	task automatic t_self();
		int n;
		wr(`SDPC_A_DIST, 32'h8);
		wr(`SDPC_A_CTRL, 32'h8);
		chk("running", 32'h1, {31'h0, run});
		rchk(`SDPC_A_CTRL, 32'h100, "ctrl running");
		for (n = 0; n < 20000 && run === 1'b1; n++) @(posedge aclk);
		chk("move done", 32'h0, {31'h0, run});
		wr(`SDPC_A_DIST, 32'h4000);
		wr(`SDPC_A_CTRL, 32'h8);
		wr(`SDPC_A_CTRL, 32'h10);
		chk("stopped", 32'h0, {31'h0, run});
	endtask : t_self

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_baud();
		t_gear();
		t_edge_dir();
		t_enc();
		t_track();
		t_fault();
		t_self();
		results();
	end

	// Whole run needs well under this span
	initial begin
		repeat (100000) @(posedge aclk);
		fail_count++;
		results();
	end
endmodule : tb_top
`default_nettype wire
